// File: bcd_out_pkg.sv
// constants and timing for the bcd result output port
// Summary of operation
// - about 30 ms after request rises, data is placed and valid asserted.
// - in single sampling, valid drops 40 ms after it rose.
// - data stays driven 16 ms after valid drops, then released off.
// - in continuous sampling, while request is held, fresh data is output every 64 ms.
// - hold during a data switch gives old or new data, never low.
// - request and hold inputs are active low.
package bcd_out_pkg;
	localparam int data_width = 20;
	localparam int fifo_depth = 8;
	localparam int clk_hz = 25000000;
	localparam int setup_ms = 30;
	localparam int valid_ms = 40;
	localparam int tail_ms = 16;
	localparam int period_ms = 64;
	localparam int setup_cycles = setup_ms * (clk_hz / 1000);
	localparam int valid_cycles = valid_ms * (clk_hz / 1000);
	localparam int tail_cycles = tail_ms * (clk_hz / 1000);
	localparam int period_cycles = period_ms * (clk_hz / 1000);
	localparam int timer_width = 32;
	typedef enum logic [2:0] {idle_st, setup_st, valid_st, tail_st, cont_st} phase_type;
endpackage

// File: bcd_fifo.sv
// no logic here: the fifo module sits beside the port logic in the block's design file

// File: bcd_result_output_handshake.sv
// bcd result output port: request/valid sequencing with hold
`timescale 1ns/10ps
`default_nettype none
module bcd_result_output_handshake
	import bcd_out_pkg::*;
#(
	parameter int setup_count = setup_cycles,
	parameter int valid_count = valid_cycles,
	parameter int tail_count = tail_cycles,
	parameter int period_count = period_cycles
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic request_n,
	input wire logic hold_n,
	input wire logic continuous,
	input wire logic meas_valid,
	output logic meas_ready,
	input wire logic [data_width-1:0] meas_data,
	output logic [data_width-1:0] bcd_data,
	output logic data_on,
	output logic data_valid_n
);
	logic rst_sync1;
	logic rst_n;
	logic req_d;
	logic request;
	logic hold;
	logic req_rise;
	phase_type phase;
	logic [timer_width-1:0] timer;
	logic [data_width-1:0] latest;
	logic fifo_valid;
	logic [data_width-1:0] fifo_data;
	logic load;
	logic load_first;
	logic load_next;

	// end of a timed phase; shared by the sequencer and the output flops
	function automatic logic at_end(input logic [timer_width-1:0] t, input int count);
		return t == timer_width'(count - 1);
	endfunction

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_n <= rst_sync1;
		end
	end

	assign request = !request_n;
	assign hold = !hold_n;
	assign req_rise = request && !req_d;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_d <= 1'b0;
		end else begin
			req_d <= request;
		end
	end

	// fifo is popped every cycle (out_ready tied high) whatever the port is doing, so it holds at most one word; each word drained goes to latest
	bcd_fifo #(.width(data_width), .depth(fifo_depth)) i_bcd_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.in_valid(meas_valid),
		.in_ready(meas_ready),
		.in_data(meas_data),
		.out_valid(fifo_valid),
		.out_ready(1'b1),
		.out_data(fifo_data)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latest <= '0;
		end else if (fifo_valid) begin
			latest <= fifo_data;
		end
	end

	// sequence only starts from a request edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= idle_st;
			timer <= '0;
		end else begin
			unique case (phase)
				idle_st: begin
					timer <= '0;
					if (req_rise) begin
						phase <= setup_st;
					end
				end
				setup_st: begin
					if (at_end(timer, setup_count)) begin
						timer <= '0;
						phase <= continuous ? cont_st : valid_st;
					end else begin
						timer <= timer + 1'b1;
					end
				end
				valid_st: begin
					if (at_end(timer, valid_count)) begin
						timer <= '0;
						phase <= tail_st;
					end else begin
						timer <= timer + 1'b1;
					end
				end
				tail_st: begin
					if (at_end(timer, tail_count)) begin
						timer <= '0;
						phase <= idle_st;
					end else begin
						timer <= timer + 1'b1;
					end
				end
				cont_st: begin
					if (!request) begin
						timer <= '0;
						phase <= tail_st;
					end else if (at_end(timer, period_count)) begin
						timer <= '0;
					end else begin
						timer <= timer + 1'b1;
					end
				end
			endcase
		end
	end

	// load at start and each period boundary
	assign load_first = (phase == setup_st) && at_end(timer, setup_count);
	assign load_next = (phase == cont_st) && request && at_end(timer, period_count);
	assign load = load_first || load_next;

	// hold freezes refreshes only
	// first word of a sequence is always taken, so a hold never exposes the reset zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bcd_data <= '0;
		end else if (load_first || (load_next && !hold)) begin
			bcd_data <= latest;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_on <= 1'b0;
		end else begin
			data_on <= (phase == valid_st) || (phase == cont_st)
				|| (phase == tail_st && !at_end(timer, tail_count)) || load;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_valid_n <= 1'b1;
		end else begin
			data_valid_n <= !((phase == valid_st && !at_end(timer, valid_count)) || load
				|| (phase == cont_st && request));
		end
	end
endmodule

// small synchronous fifo with valid/ready on both sides; full when count reaches depth
module bcd_fifo
	import bcd_out_pkg::*;
#(
	parameter int width = data_width,
	parameter int depth = fifo_depth
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw-1:0] wr_ptr;
	logic [aw-1:0] rd_ptr;
	logic [aw:0] count;
	logic push;
	logic pop;
	assign in_ready = (count != (aw+1)'(depth));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (aw+1)'(push) - (aw+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// File: bcd_result_output_handshake_properties.sv
// pin-level assertions for the bcd result port
`timescale 1ns/10ps
`default_nettype none
module bcd_port_checker
	import bcd_out_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic request_n,
	input wire logic hold_n,
	input wire logic continuous,
	input wire logic [data_width-1:0] bcd_data,
	input wire logic data_on,
	input wire logic data_valid_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	start_valid_a: assert property ($fell(request_n) && !data_on |-> ##[3:8] !data_valid_n)
		else $error("valid late after request");
	valid_len_a: assert property ($fell(data_valid_n) && !continuous |-> ##[3:5] data_valid_n)
		else $error("valid length wrong");
	tail_hold_a: assert property ($rose(data_valid_n) && !continuous |-> data_on ##[1:3] !data_on)
		else $error("data tail wrong");
	hold_keep_a: assert property (!hold_n && $past(!hold_n) && $past(data_on) && data_on |-> $stable(bcd_data))
		else $error("data moved under hold");
	never_low_a: assert property (data_on |-> bcd_data != '0)
		else $error("data went low");
	no_request_a: assert property (!data_on && request_n && $past(request_n)
		&& $past(request_n, 2) && $past(request_n, 3) |=> !data_on)
		else $error("start without request");
	one_shot_a: assert property ($rose(data_valid_n) && !continuous |=> data_valid_n [*3])
		else $error("extra valid in single");
	cover property ($rose(data_valid_n) && !continuous);
	cover property (!data_valid_n && continuous);
	cover property (!hold_n && data_on);
endmodule
bind bcd_result_output_handshake bcd_port_checker i_bcd_port_checker (.core_clk, .arst_n, .request_n,
	.hold_n, .continuous, .bcd_data, .data_on, .data_valid_n);
`default_nettype wire

// File: bcd_reader_model.sv
// reader model sampling the bcd lines
`timescale 1ns/10ps
`default_nettype none
module bcd_reader_model
	import bcd_out_pkg::*;
(
	input wire logic core_clk,
	input wire logic data_on,
	input wire logic data_valid_n,
	input wire logic [data_width-1:0] bcd_data,
	output logic [data_width-1:0] got
);
	// read only once low valid is on
	always_ff @(posedge core_clk) begin
		if (!data_valid_n && data_on) begin
			got <= bcd_data;
		end
	end
endmodule
`default_nettype wire

// File: bcd_result_output_handshake_test.sv
// self-checking bench for the bcd result port
`timescale 1ns/10ps
`default_nettype none
module bcd_result_output_handshake_test;
	import bcd_out_pkg::*;
	logic core_clk = 0, arst_n = 0, request_n = 1, hold_n = 1, continuous = 0, meas_valid = 0;
	logic meas_ready, data_on, data_valid_n;
	logic [data_width-1:0] meas_data = '0, bcd_data, got;
	int errors = 0, checks = 0, cycles = 0;
	always #20 core_clk = ~core_clk;
	bcd_result_output_handshake #(.setup_count(3), .valid_count(4), .tail_count(2), .period_count(5))
		i_bcd_result_output_handshake (.core_clk, .arst_n, .request_n, .hold_n, .continuous, .meas_valid,
		.meas_ready, .meas_data, .bcd_data, .data_on, .data_valid_n);
	bcd_reader_model i_bcd_reader_model (.core_clk, .data_on, .data_valid_n, .bcd_data, .got);
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic cmp(logic [data_width-1:0] act, logic [data_width-1:0] exp);
		checks++;
		if (act !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic push(logic [data_width-1:0] w);
		meas_data = w;
		meas_valid = 1;
		while (meas_ready !== 1'b1) step(1);
		step(1);
		meas_valid = 0;
	endtask
	task automatic reset_test();
		cmp({17'h0, meas_ready, data_on, data_valid_n}, 20'h00005);
		cmp(bcd_data, 20'h00000);
		$display("reset test done");
	endtask
	task automatic abort_test();
		request_n = 0;
		wait_valid(0);
		arst_n = 0;
		step(1);
		cmp({17'h0, meas_ready, data_on, data_valid_n}, 20'h00005);
		request_n = 1;
		step(1);
		arst_n = 1;
		step(3);
		cmp({17'h0, meas_ready, data_on, data_valid_n}, 20'h00005);
		cmp(bcd_data, 20'h00000);
		$display("abort test done");
	endtask
	task automatic wait_valid(logic lvl);
		for (int n = 0; n < 40 && data_valid_n !== lvl; n++) step(1);
		cmp({19'h0, data_valid_n}, {19'h0, lvl});
	endtask
	task automatic single_test();
		push(20'h12345);
		step(2);
		request_n = 0;
		wait_valid(0);
		step(1);
		cmp(got, 20'h12345);
		request_n = 1;
		step(1);
		request_n = 0;
		wait_valid(1);
		cmp({19'h0, data_on}, 20'h00001);
		step(8);
		cmp({18'h0, data_valid_n, data_on}, 20'h00002);
		request_n = 1;
		$display("single test done");
	endtask
	task automatic cont_test();
		continuous = 1;
		push(20'h11111);
		step(1);
		request_n = 0;
		wait_valid(0);
		push(20'h22222);
		step(12);
		cmp(bcd_data, 20'h22222);
		hold_n = 0;
		push(20'h33333);
		step(12);
		cmp(bcd_data, 20'h22222);
		hold_n = 1;
		step(12);
		cmp(bcd_data, 20'h33333);
		request_n = 1;
		wait_valid(1);
		step(4);
		cmp({19'h0, data_on}, 20'h00000);
		continuous = 0;
		$display("continuous test done");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		step(3);
		arst_n = 1;
		step(3);
		reset_test();
		single_test();
		cont_test();
		abort_test();
		final_report();
	end
endmodule
`default_nettype wire
